/* File: cri_pkg.sv */
// Purpose: Shared constants for the CPU register and interrupt core
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Offsets, command bits, mode codes and restart addresses live here
package cri_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_BANK_BASE   = 8'h00;
   localparam logic [7:0] OFF_IDX_FIRST   = 8'h20;
   localparam logic [7:0] OFF_IDX_SECOND  = 8'h24;
   localparam logic [7:0] OFF_STACK_TOP   = 8'h28;
   localparam logic [7:0] OFF_PROG_CNT    = 8'h2C;
   localparam logic [7:0] OFF_VEC_REFRESH = 8'h30;
   localparam logic [7:0] OFF_STATUS      = 8'h34;
   localparam logic [7:0] OFF_CMD         = 8'h38;

   // ------------------------------------------------------------
   // Command register bits (write-one pulses)
   // ------------------------------------------------------------
   localparam int CMD_EX_ACC   = 0;
   localparam int CMD_EX_GEN   = 1;
   localparam int CMD_EN_IRQ   = 2;
   localparam int CMD_DIS_IRQ  = 3;
   localparam int CMD_RET_NMI  = 4;
   localparam int CMD_MODE0    = 5;
   localparam int CMD_MODE1    = 6;
   localparam int CMD_MODE2    = 7;

   // ------------------------------------------------------------
   // Mode codes, restart addresses, reset values, timing
   // ------------------------------------------------------------
   localparam logic [1:0]  IM_MODE0     = 2'b00;
   localparam logic [1:0]  IM_MODE1     = 2'b10;
   localparam logic [1:0]  IM_MODE2     = 2'b11;
   localparam logic [15:0] RST_NMI      = 16'h0066;
   localparam logic [15:0] RST_MODE1    = 16'h0038;
   localparam logic [15:0] RESET_WORD   = 16'h0000;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [7:0]  VEC_LOW_MASK = 8'hFE;
   localparam int          ACK_WAIT_STATES = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ACK_ADDR, ST_ACK_WAIT, ST_ACK_READ, ST_REFRESH
   } cri_state_e;
endpackage : cri_pkg

/* File: cri_core.sv */
// Purpose: Register file and interrupt acceptance of an 8-bit CPU, APB slave
// Assumes: Interrupt, bus request and data pins are asynchronous
// Notes:   instrLastClock and fetchRefresh come from sequencing logic on clk
//
// Function
// - Main and alternate accumulator, flags and six general registers; exchanges swap.
// - General registers pair as three 16-bit words, first name high byte.
// - Eight-bit vector page base gives upper address byte for vectored interrupts.
// - Two 16-bit index registers, stack pointer and program counter.
// - Enable flop 1 means enabled; shadow keeps it during nonmaskable service.
// - Two mode flops select one of three maskable modes; nonmaskable fixed.
// - Nonmaskable input wins; maskable input needs software enable.
// - Both requests sampled at last clock of each instruction.
// - Nonmaskable request accepted regardless of any software setting.
// - Accepted nonmaskable request without bus request jumps to 0066H.
// - Maskable acknowledge needs enable and no bus request; same timing always.
// - Acknowledge is an opcode fetch with I/O strobe instead of memory strobe.
// - Two wait states inserted into the acknowledge fetch.
// - Mode 1 jumps to restart address 0038H.
// - Vectored mode pointer is base register high, supplied vector low.
// - Reset and disable clear both enable flops; enable sets both.
`timescale 1ns/1ns
module cri_core
   import cri_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              nmiRequestN,
   input  wire logic              irqRequestN,
   input  wire logic              busRequestN,
   input  wire logic [7:0]        dataBusIn,
   input  wire logic              instrLastClock,
   input  wire logic              fetchRefresh,
   output logic      [15:0]       addressBus,
   output logic                   memoryRequestN,
   output logic                   ioRequestN,
   output logic                   opcodeFetchN,
   output logic                   refreshStrobeN,
   output logic                   nmiTaken,
   output logic                   irqAckDone
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [15:0] bank_reg [0:1][0:3];
   logic        accSel_reg;
   logic        genSel_reg;
   logic [15:0] indexFirst_reg;
   logic [15:0] indexSecond_reg;
   logic [15:0] stackTopPointer_reg;
   logic [15:0] programCounter_reg;
   logic [7:0]  vectorPageBase_reg;
   logic [7:0]  refreshCounter_reg;
   logic        irqEnableFf_reg;
   logic        irqEnableShadowFf_reg;
   logic        irqModeFfHigh_reg;
   logic        irqModeFfLow_reg;
   logic        nmiPending_reg;
   logic        nmiPrev_reg;
   logic [10:0] pinSync1_reg;
   logic [10:0] pinSync2_reg;
   logic [7:0]  lastVector_reg;
   logic [15:0] tablePointer_reg;
   logic [0:0]  waitCnt_reg;
   cri_state_e  state_reg;

   logic        apbWr;
   logic        addrOk;
   logic [7:0]  cmd;
   logic [31:0] readMux;
   logic        nmiSync;
   logic        irqSync;
   logic        busFree;
   logic [7:0]  dataSync;
   logic [1:0]  irqMode;
   logic        nmiAccept;
   logic        irqAccept;
   logic        ackDone;
   logic        refreshDone;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // request, bus request and data pins, two flops each
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinSync1_reg <= 11'h7FF;
         pinSync2_reg <= 11'h7FF;
      end else begin
         pinSync1_reg <= {dataBusIn, busRequestN, irqRequestN, nmiRequestN};
         pinSync2_reg <= pinSync1_reg;
      end
   end

   assign nmiSync  = pinSync2_reg[0];
   assign irqSync  = pinSync2_reg[1];
   assign busFree  = pinSync2_reg[2];
   assign dataSync = pinSync2_reg[10:3];
   assign irqMode  = {irqModeFfHigh_reg, irqModeFfLow_reg};

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Write lands on the edge where the master sees pready high
   assign apbWr  = psel & penable & pready & pwrite;
   assign addrOk = (paddr[1:0] == 2'b00) && (paddr <= OFF_CMD);
   assign cmd    = (apbWr && paddr == OFF_CMD) ? pwdata[7:0] : 8'h00;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addrOk;
         if (psel & penable & ~pready) begin
            prdata <= readMux;
         end
      end
   end

   always_comb begin
      readMux = 32'h0000_0000;
      if (addrOk && paddr < OFF_IDX_FIRST) begin
         readMux[15:0] = bank_reg[paddr[4] ^ ((paddr[3:2] == 2'b00) ? accSel_reg : genSel_reg)]
                                 [paddr[3:2]];
      end else if (addrOk) begin
         case (paddr)
            OFF_IDX_FIRST:   readMux[15:0] = indexFirst_reg;
            OFF_IDX_SECOND:  readMux[15:0] = indexSecond_reg;
            OFF_STACK_TOP:   readMux[15:0] = stackTopPointer_reg;
            OFF_PROG_CNT:    readMux[15:0] = programCounter_reg;
            OFF_VEC_REFRESH: readMux[15:0] = {vectorPageBase_reg, refreshCounter_reg};
            OFF_STATUS: readMux = {tablePointer_reg, lastVector_reg, genSel_reg, accSel_reg,
                                   nmiPending_reg, (state_reg != ST_IDLE), irqModeFfLow_reg,
                                   irqModeFfHigh_reg, irqEnableShadowFf_reg, irqEnableFf_reg};
            default:         readMux = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register banks and exchange
   // ------------------------------------------------------------
   // exchange flips the active set
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         accSel_reg <= 1'b0;
         genSel_reg <= 1'b0;
      end else begin
         if (cmd[CMD_EX_ACC]) accSel_reg <= ~accSel_reg;
         if (cmd[CMD_EX_GEN]) genSel_reg <= ~genSel_reg;
      end
   end

   // Offsets 00..0C hit the active set, 10..1C the inactive one
   for (genvar s = 0; s < 2; s++) begin : gSet
      for (genvar p = 0; p < 4; p++) begin : gPair
         logic hit;
         logic sel;
         assign sel = (p == 0) ? accSel_reg : genSel_reg;
         assign hit = apbWr && addrOk && paddr < OFF_IDX_FIRST &&
                      paddr[3:2] == 2'(p) && (paddr[4] == (sel ^ 1'(s)));
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               bank_reg[s][p] <= RESET_WORD;
            end else if (hit) begin
               bank_reg[s][p] <= pwdata[15:0];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Index, stack and vector registers
   // ------------------------------------------------------------
   // index and stack words
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         indexFirst_reg      <= RESET_WORD;
         indexSecond_reg     <= RESET_WORD;
         stackTopPointer_reg <= RESET_WORD;
      end else if (apbWr) begin
         if (paddr == OFF_IDX_FIRST)  indexFirst_reg      <= pwdata[15:0];
         if (paddr == OFF_IDX_SECOND) indexSecond_reg     <= pwdata[15:0];
         if (paddr == OFF_STACK_TOP)  stackTopPointer_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         vectorPageBase_reg <= RESET_BYTE;
         refreshCounter_reg <= RESET_BYTE;
      end else if (apbWr && paddr == OFF_VEC_REFRESH) begin
         vectorPageBase_reg <= pwdata[15:8];
         refreshCounter_reg <= pwdata[7:0];
      end else if (refreshDone) begin
         refreshCounter_reg <= {refreshCounter_reg[7], refreshCounter_reg[6:0] + 7'h01};
      end
   end

   refresh_incr_a: assert property (refreshDone && !(apbWr && paddr == OFF_VEC_REFRESH)
      |=> refreshCounter_reg[6:0] == $past(refreshCounter_reg[6:0]) + 7'h01 &&
          refreshCounter_reg[7] == $past(refreshCounter_reg[7]))
      else $error("refresh counter step wrong");

   // ------------------------------------------------------------
   // Interrupt acceptance
   // ------------------------------------------------------------
   // sample at last instruction clock
   assign nmiAccept = instrLastClock && state_reg == ST_IDLE && nmiPending_reg && busFree;
   // maskable needs enable, loses to nonmaskable
   // no bus request during acknowledge start
   assign irqAccept = instrLastClock && state_reg == ST_IDLE && !nmiPending_reg &&
                      !irqSync && irqEnableFf_reg && busFree;
   assign ackDone     = (state_reg == ST_ACK_READ);
   assign refreshDone = (state_reg == ST_REFRESH);

   // Edge is latched so a short pulse between instruction ends is kept; set wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nmiPrev_reg    <= 1'b1;
         nmiPending_reg <= 1'b0;
      end else begin
         nmiPrev_reg <= nmiSync;
         if (nmiPrev_reg && !nmiSync) nmiPending_reg <= 1'b1;
         else if (nmiAccept)          nmiPending_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqEnableFf_reg       <= 1'b0;
         irqEnableShadowFf_reg <= 1'b0;
      end else if (nmiAccept) begin
         irqEnableShadowFf_reg <= irqEnableFf_reg;
         irqEnableFf_reg       <= 1'b0;
      end else if (irqAccept || cmd[CMD_DIS_IRQ]) begin
         irqEnableFf_reg       <= 1'b0;
         irqEnableShadowFf_reg <= 1'b0;
      end else if (cmd[CMD_EN_IRQ]) begin
         irqEnableFf_reg       <= 1'b1;
         irqEnableShadowFf_reg <= 1'b1;
      end else if (cmd[CMD_RET_NMI]) begin
         irqEnableFf_reg <= irqEnableShadowFf_reg;
      end
   end

   nmi_shadow_a: assert property (nmiAccept
      |=> !irqEnableFf_reg && irqEnableShadowFf_reg == $past(irqEnableFf_reg))
      else $error("shadow not saved on nonmaskable accept");
   return_from_nonmaskable_copy_a: assert property (cmd[CMD_RET_NMI] && !cmd[CMD_EN_IRQ] && !cmd[CMD_DIS_IRQ] &&
      !nmiAccept && !irqAccept |=> irqEnableFf_reg == $past(irqEnableShadowFf_reg))
      else $error("return did not restore enable");
   enable_both_a: assert property (cmd[CMD_EN_IRQ] && !cmd[CMD_DIS_IRQ] && !nmiAccept &&
      !irqAccept |=> irqEnableFf_reg && irqEnableShadowFf_reg)
      else $error("enable did not set both flops");

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {irqModeFfHigh_reg, irqModeFfLow_reg} <= IM_MODE0;
      end else if (cmd[CMD_MODE2]) begin
         {irqModeFfHigh_reg, irqModeFfLow_reg} <= IM_MODE2;
      end else if (cmd[CMD_MODE1]) begin
         {irqModeFfHigh_reg, irqModeFfLow_reg} <= IM_MODE1;
      end else if (cmd[CMD_MODE0]) begin
         {irqModeFfHigh_reg, irqModeFfLow_reg} <= IM_MODE0;
      end
   end

   // ------------------------------------------------------------
   // Program counter and vector capture
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         programCounter_reg <= RESET_WORD;
      end else if (nmiAccept) begin
         programCounter_reg <= RST_NMI;
      end else if (ackDone && irqMode == IM_MODE1) begin
         programCounter_reg <= RST_MODE1;
      end else if (apbWr && paddr == OFF_PROG_CNT) begin
         programCounter_reg <= pwdata[15:0];
      end
   end

   nmi_restart_a: assert property (nmiAccept |=> programCounter_reg == RST_NMI)
      else $error("nonmaskable restart address wrong");
   mode1_restart_a: assert property (ackDone && irqMode == IM_MODE1
      |=> programCounter_reg == RST_MODE1)
      else $error("mode 1 restart address wrong");

   // Mode 0 keeps the byte for the sequencer to execute
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lastVector_reg   <= RESET_BYTE;
         tablePointer_reg <= RESET_WORD;
      end else if (ackDone) begin
         lastVector_reg <= dataSync;
         if (irqMode == IM_MODE2) tablePointer_reg <= {vectorPageBase_reg, dataSync};
      end
   end

   table_ptr_a: assert property (ackDone && irqMode == IM_MODE2
      |=> tablePointer_reg == {$past(vectorPageBase_reg), $past(dataSync)})
      else $error("vector table pointer wrong");

   // ------------------------------------------------------------
   // Acknowledge and refresh cycle sequencer
   // ------------------------------------------------------------
   // one timing for every mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg   <= ST_IDLE;
         waitCnt_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (irqAccept)         state_reg <= ST_ACK_ADDR;
               else if (fetchRefresh) state_reg <= ST_REFRESH;
            end
            ST_ACK_ADDR: begin
               state_reg   <= ST_ACK_WAIT;
               waitCnt_reg <= 1'b0;
            end
            ST_ACK_WAIT: begin
               waitCnt_reg <= waitCnt_reg + 1'b1;
               if (waitCnt_reg == 1'(ACK_WAIT_STATES - 1)) state_reg <= ST_ACK_READ;
            end
            ST_ACK_READ: state_reg <= ST_IDLE;
            ST_REFRESH:  state_reg <= ST_IDLE;
            default:     state_reg <= ST_IDLE;
         endcase
      end
   end

   sequence ackWaits;
      (state_reg == ST_ACK_WAIT) [*2] ##1 (state_reg == ST_ACK_READ);
   endsequence
   ack_wait_states_a: assert property (state_reg == ST_ACK_ADDR |=> ackWaits)
      else $error("acknowledge wait states wrong");
   ack_gated_a: assert property (state_reg == ST_IDLE ##1 state_reg == ST_ACK_ADDR
      |-> $past(irqEnableFf_reg) && $past(busFree))
      else $error("acknowledge started while masked");

   // Bus strobes are registered from the next state so they stay glitch free
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addressBus     <= RESET_WORD;
         memoryRequestN <= 1'b1;
         ioRequestN     <= 1'b1;
         opcodeFetchN   <= 1'b1;
         refreshStrobeN <= 1'b1;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (irqAccept) begin
                  addressBus   <= programCounter_reg;
                  opcodeFetchN <= 1'b0;
               end else if (fetchRefresh) begin
                  // all eight bits on the bus
                  addressBus     <= {vectorPageBase_reg, refreshCounter_reg};
                  memoryRequestN <= 1'b0;
                  refreshStrobeN <= 1'b0;
               end
            end
            ST_ACK_ADDR: ioRequestN <= 1'b0;
            ST_ACK_READ: begin
               ioRequestN   <= 1'b1;
               opcodeFetchN <= 1'b1;
            end
            ST_REFRESH: begin
               memoryRequestN <= 1'b1;
               refreshStrobeN <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   ack_strobe_a: assert property (!ioRequestN |-> !opcodeFetchN && memoryRequestN)
      else $error("acknowledge strobes wrong");

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nmiTaken   <= 1'b0;
         irqAckDone <= 1'b0;
      end else begin
         nmiTaken   <= nmiAccept;
         irqAckDone <= ackDone;
      end
   end

   exchange_a: assert property (cmd[CMD_EX_ACC] |=> accSel_reg != $past(accSel_reg))
      else $error("exchange did not switch set");
endmodule : cri_core

/* File: cri_periph_model.sv */
// Purpose: Interrupting peripherals and data bus beside the core
// Assumes: Two requesters share the maskable request line
// Notes:   Idle data bus shows a changing pattern, never a held value
`timescale 1ns/1ns
module cri_periph_model
   import cri_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] irqAsk,
   input  wire logic       nmiAsk,
   input  wire logic [7:0] vecByte,
   input  wire logic       opcodeFetchN,
   output logic            irqRequestN,
   output logic            nmiRequestN,
   output logic [7:0]      dataBusIn
);
   assign irqRequestN = ~(|irqAsk);
   assign nmiRequestN = ~nmiAsk;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dataBusIn <= 8'hA5;
      end else if (opcodeFetchN === 1'b0) begin
         dataBusIn <= vecByte & VEC_LOW_MASK;
      end else begin
         dataBusIn <= ~dataBusIn;
      end
   end
endmodule : cri_periph_model

/* File: cri_core_tb_top.sv */
// Purpose: Self-checking bench for the register and interrupt core
// Assumes: APB master, pins settle within four clocks
// Notes:   Counters watch the strobes; a hung transfer ends the run
`timescale 1ns/1ns
module cri_core_tb_top;
   import cri_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cri_row_s;
   // ----------------
   // Signals
   // ----------------
   logic        clk, reset, psel, penable, pwrite, instrLastClock, fetchRefresh;
   logic        busRequestN, nmiAsk, pready, pslverr, irqRequestN, nmiRequestN, rdErr;
   logic        memoryRequestN, ioRequestN, opcodeFetchN, refreshStrobeN, nmiTaken, irqAckDone;
   logic [1:0]  irqAsk;
   logic [7:0]  paddr, dataBusIn, vecByte;
   logic [15:0] addressBus, ackAddr, refAddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic [1:0]  modes [3] = '{IM_MODE0, IM_MODE1, IM_MODE2};
   int          failures, checks, nFetch, nIo, nMem;
   cri_row_s    rows [10] = '{'{8'h00, 32'hA55A, 32'hA55A}, '{8'h04, 32'h1234, 32'h1234},
      '{8'h08, 32'h5678, 32'h5678}, '{8'h0C, 32'h9ABC, 32'h9ABC}, '{8'h10, 32'h1111, 32'h1111},
      '{8'h14, 32'h2222, 32'h2222}, '{8'h20, 32'hFFFFBEEF, 32'hBEEF},
      '{8'h24, 32'hCAFE, 32'hCAFE}, '{8'h28, 32'hFFFE, 32'hFFFE}, '{8'h2C, 32'h1000, 32'h1000}};
   cri_core dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmiRequestN(nmiRequestN), .irqRequestN(irqRequestN), .busRequestN(busRequestN),
      .dataBusIn(dataBusIn), .instrLastClock(instrLastClock), .fetchRefresh(fetchRefresh),
      .addressBus(addressBus), .memoryRequestN(memoryRequestN), .ioRequestN(ioRequestN),
      .opcodeFetchN(opcodeFetchN), .refreshStrobeN(refreshStrobeN), .nmiTaken(nmiTaken),
      .irqAckDone(irqAckDone));
   cri_periph_model periph (.clk(clk), .reset(reset), .irqAsk(irqAsk), .nmiAsk(nmiAsk),
      .vecByte(vecByte), .opcodeFetchN(opcodeFetchN), .irqRequestN(irqRequestN),
      .nmiRequestN(nmiRequestN), .dataBusIn(dataBusIn));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (opcodeFetchN === 1'b0) begin nFetch++; ackAddr = addressBus; end
      if (ioRequestN === 1'b0) nIo++;
      if (memoryRequestN === 1'b0) nMem++;
      if (refreshStrobeN === 1'b0) refAddr = addressBus;
   end
   // ----------------
   // Tasks
   // ----------------
   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      // Hung slave counts as a mismatch and ends the run
      if (n >= 50) begin failures++; test_done(); end
      rdVal = prdata; rdErr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : xfer
   task automatic rdChk(input string w, input logic [7:0] a, input logic [31:0] m, e);
      xfer(1'b0, a, 32'h0);
      chk(w, e, rdVal & m);
   endtask : rdChk
   task automatic cmd(input int k);
      xfer(1'b1, OFF_CMD, 32'h0000_0001 << k);
   endtask : cmd
   task automatic clr;
      @(negedge clk);
      nFetch = 0; nIo = 0; nMem = 0;
      @(posedge clk);
   endtask : clr
   // Pins need time through the synchronisers before the sampling pulse
   task automatic pulse;
      repeat (4) @(posedge clk);
      instrLastClock <= 1'b1;
      @(posedge clk);
      instrLastClock <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : pulse
   // ----------------
   // Sequence
   // ----------------
   initial begin
      reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; instrLastClock = 1'b0; fetchRefresh = 1'b0; busRequestN = 1'b1;
      nmiAsk = 1'b0; irqAsk = 2'b00; vecByte = 8'h46; failures = 0; checks = 0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rdChk("status", OFF_STATUS, 32'hFFFFFFFF, 32'h0);
      foreach (rows[i]) xfer(1'b1, rows[i].a, rows[i].d);
      foreach (rows[i]) rdChk("reg", rows[i].a, 32'hFFFFFFFF, rows[i].e);
      cmd(CMD_EX_ACC);
      rdChk("acc", OFF_BANK_BASE, 32'hFFFF, 32'h1111);
      rdChk("acc alt", 8'h10, 32'hFFFF, 32'hA55A);
      cmd(CMD_EX_GEN);
      rdChk("pair", 8'h04, 32'hFFFF, 32'h2222);
      cmd(CMD_EN_IRQ);
      rdChk("enable", OFF_STATUS, 32'h3, 32'h3);
      for (int k = 0; k < 3; k++) begin
         cmd(CMD_MODE0 + k);
         rdChk("mode", OFF_STATUS, 32'hC, {28'h0, modes[k][0], modes[k][1], 2'b00});
      end
      cmd(CMD_MODE1);
      clr();
      irqAsk <= 2'b10; busRequestN <= 1'b0;
      repeat (8) @(posedge clk);
      chk("fetch idle", 0, nFetch);
      pulse();
      chk("fetch bus_request_n", 0, nFetch);
      busRequestN <= 1'b1;
      pulse();
      chk("fetch", 4, nFetch);
      chk("io", 3, nIo);
      chk("mem", 0, nMem);
      chk("ack addr", 16'h1000, ackAddr);
      rdChk("pc", OFF_PROG_CNT, 32'hFFFFFFFF, RST_MODE1);
      rdChk("enable", OFF_STATUS, 32'h3, 32'h0);
      irqAsk <= 2'b00;
      xfer(1'b1, OFF_VEC_REFRESH, 32'h12FF);
      fetchRefresh <= 1'b1;
      @(posedge clk);
      fetchRefresh <= 1'b0;
      repeat (4) @(posedge clk);
      chk("refresh bus", 16'h12FF, refAddr);
      rdChk("refresh", OFF_VEC_REFRESH, 32'hFFFFFFFF, 32'h1280);
      cmd(CMD_EN_IRQ);
      cmd(CMD_MODE2);
      clr();
      irqAsk <= 2'b01;
      pulse();
      chk("fetch mode2", 4, nFetch);
      rdChk("pointer", OFF_STATUS, 32'hFFFFFF00, 32'h12464600);
      cmd(CMD_EN_IRQ);
      cmd(CMD_MODE0);
      clr();
      vecByte <= 8'hC6;
      pulse();
      chk("fetch mode0", 4, nFetch);
      rdChk("mode0 byte", OFF_STATUS, 32'hFFFFFF00, 32'h1246C600);
      rdChk("pc mode0", OFF_PROG_CNT, 32'hFFFFFFFF, RST_MODE1);
      cmd(CMD_EN_IRQ);
      clr();
      irqAsk <= 2'b11; nmiAsk <= 1'b1;
      pulse();
      chk("fetch nmi", 0, nFetch);
      rdChk("pc nmi", OFF_PROG_CNT, 32'hFFFFFFFF, RST_NMI);
      rdChk("shadow", OFF_STATUS, 32'h3, 32'h2);
      irqAsk <= 2'b00; nmiAsk <= 1'b0;
      cmd(CMD_RET_NMI);
      rdChk("restore", OFF_STATUS, 32'h3, 32'h3);
      cmd(CMD_DIS_IRQ);
      rdChk("disable", OFF_STATUS, 32'h3, 32'h0);
      xfer(1'b1, OFF_PROG_CNT, 32'h2000);
      nmiAsk <= 1'b1;
      pulse();
      rdChk("pc masked", OFF_PROG_CNT, 32'hFFFFFFFF, RST_NMI);
      xfer(1'b0, 8'h3C, 32'h0);
      chk("unmapped err", 1, rdErr);
      chk("unmapped data", 0, rdVal);
      test_done();
   end
endmodule : cri_core_tb_top
